/* File: common/cansil_regs.vh */
// Register offsets, field positions, reset values and timing counts of the CAN status block
`ifndef CANSIL_REGS_VH
`define CANSIL_REGS_VH
// Word indices (byte address = 4 * index)
`define CANSIL_IDX_GSTA 4'h0
`define CANSIL_IDX_GIT 4'h1
`define CANSIL_IDX_GIE 4'h2
`define CANSIL_IDX_INUSE_LO 4'h3
`define CANSIL_IDX_INUSE_HI 4'h4
`define CANSIL_IDX_OIE_LO 4'h5
`define CANSIL_IDX_OIE_HI 4'h6
`define CANSIL_IDX_PEND_LO 4'h7
`define CANSIL_IDX_PEND_HI 4'h8
`define CANSIL_IDX_BT1 4'h9
`define CANSIL_IDX_CTRL 4'hA
// Status bit positions
`define CANSIL_ST_TXACT 4
`define CANSIL_ST_RXACT 3
`define CANSIL_ST_ENFLAG 2
`define CANSIL_ST_BUSOFF 1
`define CANSIL_ST_ERROR_PASSIVE_STATE 0
// Flag bit positions
`define CANSIL_GF_SUM 7
`define CANSIL_GF_BUS_OFF_STATE 6
`define CANSIL_GF_OVR 5
`define CANSIL_GF_FBUF 4
`define CANSIL_GF_STUFF 3
`define CANSIL_GF_CRC 2
`define CANSIL_GF_FORM 1
`define CANSIL_GF_ACK 0
// Enable bit positions
`define CANSIL_GE_MASTER 7
`define CANSIL_GE_BUS_OFF_STATE 6
`define CANSIL_GE_RX 5
`define CANSIL_GE_TX 4
`define CANSIL_GE_OERR 3
`define CANSIL_GE_FBUF 2
`define CANSIL_GE_GERR 1
`define CANSIL_GE_OVR 0
// Control register bit positions
`define CANSIL_CT_ENA 1
`define CANSIL_CT_ABORT 7
// Reset values and widths
`define CANSIL_RST_BYTE 8'h00
`define CANSIL_NOBJ 6
`define CANSIL_OBJ_MASK 8'h3F
`define CANSIL_BT1_MASK 8'h7E
`define CANSIL_TIMER_MAX 16'hFFFF
// Enable takes effect after this many recessive bit times
`define CANSIL_ENA_RECESSIVE_BITS 4'hB
`endif

/* File: design/cansil_top.v */
// CAN status, interrupt flag, enable and message object availability logic
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "cansil_regs.vh"

// How it works
// (RQ1) Transmitter-active status follows the core's sending indication, no interrupt.
// (RQ2) Receiver-active status follows the core's receiving indication, no interrupt.
// (RQ3) Enabled status shows the reached mode, lagging the enable/standby command.
// (RQ4) Bus-off status is read-only; only entering bus-off raises its flag.
// (RQ5) Error-passive status is read-only and never interrupts.
// (RQ6) Summary bit ORs all controller sources except timer overrun.
// (RQ7) Writing one clears a general flag; writing zero leaves it.
// (RQ8) Bus-off flag sets only on entry into bus-off from error passive.
// (RQ9) Timer overrun flag sets on wrap to zero; handler entry clears it.
// (RQ10) Frame-buffer flag sets on completion; clear needs all configs rewritten.
// (RQ11) Stuff error event sets general stuff-error flag.
// (RQ12) CRC mismatch event sets general CRC-error flag.
// (RQ13) Form violation event sets general form-error flag.
// (RQ14) Missing acknowledge event sets general ack-error flag.
// (RQ15) Master enable gates every controller interrupt but timer overrun.
// (RQ16) Individual enables for bus-off, rx, tx, object error, buffer, general error.
// (RQ17) Timer overrun interrupt has its own enable, independent of master.
// (RQ18) In-use bit sets on configuration enable, clears on tx-ok or rx-ok.
// (RQ19) In-use bit also clears on disable, abort request or standby.
// (RQ20) Six writable object interrupt enables; upper bits written zero.
// (RQ21) Six read-only object pending bits; upper bits read zero.
// (RQ22) Six-bit writable prescaler in bit-timing register; reserved bits zero.
// (RQ23) Time quantum is clock period times prescaler plus one.
// (RQ24) Object pending sets on rx, tx or error flag with matching enable.
// (RQ25) Errors recorded at object level set no general error flag.
// (RQ26) Controller request needs master and enabled pending source; overrun separate.
module cansil_top
(
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_transmitter_active,
  input wire i_receiver_active,
  input wire i_bus_recessive_bit,
  input wire i_bus_off_state,
  input wire i_error_passive_state,
  input wire i_timer_wrap,
  input wire i_overrun_handler_entry,
  input wire i_frame_buffer_done,
  input wire i_fbuf_config_rewritten,
  input wire i_err_stuff,
  input wire i_err_crc,
  input wire i_err_form,
  input wire i_err_ack,
  input wire i_err_at_object,
  input wire [5:0] i_obj_config_enable,
  input wire [5:0] i_obj_config_disable,
  input wire [5:0] i_obj_rx_ok,
  input wire [5:0] i_obj_tx_ok,
  input wire [5:0] i_obj_error,
  output reg o_controller_enabled_state,
  output reg o_tq_tick,
  output wire o_controller_irq,
  output wire o_timer_overrun_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Enable-state machine states
  localparam [2:0] ST_STANDBY = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_ENABLED = 3'b100;

  // Byte masked write helper
  function [7:0] cansil_wr_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
      cansil_wr_byte = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // General flag clear: a one written into the flag register
  function cansil_git_clr;
    input wr;
    input [3:0] adr;
    input bit_one;
    begin
      cansil_git_clr = wr & (adr == `CANSIL_IDX_GIT) & bit_one;
    end
  endfunction

  // Zero extension of a register byte onto the bus word
  function [31:0] cansil_byte_word;
    input [7:0] val;
    begin
      cansil_byte_word = {24'h000000, val};
    end
  endfunction

  reg [2:0] state;
  reg [3:0] recessive_cnt;
  reg [7:0] gen_flags;
  reg [7:0] gen_enables;
  reg [7:0] ctrl;
  reg [5:0] in_use;
  reg [5:0] obj_ie;
  reg [5:0] obj_pend;
  reg [7:0] bt1;
  reg [5:0] tq_cnt;
  reg bus_off_prev;
  reg err_passive_prev;
  reg ack_done;

  wire wr_ok;
  wire [7:0] wdat;
  wire [7:0] next_flags;
  wire [7:0] next_stat;
  wire bus_off_state_entry;
  wire sum_src;
  wire standby;
  wire abort;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then accepted
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_done;
  assign wr_ok = i_ce & i_avs_write & ack_done & i_avs_byteenable[0];
  assign wdat = i_avs_writedata[7:0];
  assign standby = ~ctrl[`CANSIL_CT_ENA];
  assign abort = ctrl[`CANSIL_CT_ABORT];

  // Acknowledge strobe toggles off after each accepted access
  always @(posedge i_clk)
  begin
    if (i_rst)
      ack_done <= 1'b0;
    else if (i_ce)
      ack_done <= (i_avs_read | i_avs_write) & ~ack_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte and summary
  assign next_stat = {3'b000,
    i_transmitter_active,  // RQ1
    i_receiver_active,     // RQ2
    o_controller_enabled_state, // RQ3
    i_bus_off_state,       // RQ4
    i_error_passive_state};  // RQ5
  // Transition into bus-off coming from error passive
  assign bus_off_state_entry = i_bus_off_state & ~bus_off_prev & err_passive_prev; // RQ8
  // Summary of all sources except timer overrun
  assign sum_src = (|gen_flags[`CANSIL_GF_BUS_OFF_STATE:`CANSIL_GF_BUS_OFF_STATE])
    | (|gen_flags[`CANSIL_GF_FBUF:`CANSIL_GF_ACK]) | (|obj_pend); // RQ6
  assign next_flags = {sum_src, gen_flags[6:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests
  assign o_controller_irq = gen_enables[`CANSIL_GE_MASTER] & // RQ15
    ((gen_flags[`CANSIL_GF_BUS_OFF_STATE] & gen_enables[`CANSIL_GE_BUS_OFF_STATE]) | // RQ16
     (gen_flags[`CANSIL_GF_FBUF] & gen_enables[`CANSIL_GE_FBUF]) |
     ((|gen_flags[`CANSIL_GF_STUFF:`CANSIL_GF_ACK]) & gen_enables[`CANSIL_GE_GERR]) |
     (|(obj_pend & obj_ie))); // RQ26
  assign o_timer_overrun_irq = gen_flags[`CANSIL_GF_OVR]
    & gen_enables[`CANSIL_GE_OVR]; // RQ17

  ////////////////////////////////////////////////////////////////////////////
  // Enable/standby state machine: enable after 11 recessive bits
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= ST_STANDBY;
      recessive_cnt <= 4'h0;
      o_controller_enabled_state <= 1'b0;
    end
    else if (i_ce)
    begin
      case (state)
        ST_STANDBY:
        begin
          recessive_cnt <= 4'h0;
          if (~standby)
            state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (standby)
            state <= ST_STANDBY;
          else if (o_tq_tick)
          begin
            if (!i_bus_recessive_bit)
              recessive_cnt <= 4'h0;
            else if (recessive_cnt == `CANSIL_ENA_RECESSIVE_BITS - 4'h1)
            begin
              state <= ST_ENABLED;
              o_controller_enabled_state <= 1'b1; // RQ3
            end
            else
              recessive_cnt <= recessive_cnt + 4'h1;
          end
        end
        ST_ENABLED:
        begin
          // Standby only once the ongoing transmission finished
          if (standby && !i_transmitter_active)
          begin
            state <= ST_STANDBY;
            o_controller_enabled_state <= 1'b0; // RQ3
          end
        end
        default:
        begin
          state <= ST_STANDBY;
          o_controller_enabled_state <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time quantum prescaler: tick every prescaler+1 clocks
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tq_cnt <= 6'h00;
      o_tq_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      if (tq_cnt >= bt1[6:1])
      begin
        tq_cnt <= 6'h00; // RQ23
        o_tq_tick <= 1'b1;
      end
      else
      begin
        tq_cnt <= tq_cnt + 6'h01;
        o_tq_tick <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General flags: set wins over software clear
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      gen_flags <= `CANSIL_RST_BYTE;
      bus_off_prev <= 1'b0;
      err_passive_prev <= 1'b0;
    end
    else if (i_ce)
    begin
      bus_off_prev <= i_bus_off_state;
      err_passive_prev <= i_error_passive_state;
      gen_flags[`CANSIL_GF_SUM] <= 1'b0;
      if (bus_off_state_entry)
        gen_flags[`CANSIL_GF_BUS_OFF_STATE] <= 1'b1; // RQ8
      else if (cansil_git_clr(wr_ok, i_avs_address, wdat[`CANSIL_GF_BUS_OFF_STATE]))
        gen_flags[`CANSIL_GF_BUS_OFF_STATE] <= 1'b0; // RQ7
      if (i_timer_wrap)
        gen_flags[`CANSIL_GF_OVR] <= 1'b1; // RQ9
      else if (i_overrun_handler_entry)
        gen_flags[`CANSIL_GF_OVR] <= 1'b0; // RQ9
      else if (cansil_git_clr(wr_ok, i_avs_address, wdat[`CANSIL_GF_OVR]))
        gen_flags[`CANSIL_GF_OVR] <= 1'b0; // RQ7
      if (i_frame_buffer_done)
        gen_flags[`CANSIL_GF_FBUF] <= 1'b1; // RQ10
      else if (cansil_git_clr(wr_ok, i_avs_address, wdat[`CANSIL_GF_FBUF])
               && i_fbuf_config_rewritten)
        gen_flags[`CANSIL_GF_FBUF] <= 1'b0; // RQ10
      // General error flags, suppressed when logged at object level
      if (i_err_stuff && !i_err_at_object)
        gen_flags[`CANSIL_GF_STUFF] <= 1'b1; // RQ11 RQ25
      else if (cansil_git_clr(wr_ok, i_avs_address, wdat[`CANSIL_GF_STUFF]))
        gen_flags[`CANSIL_GF_STUFF] <= 1'b0; // RQ7
      if (i_err_crc && !i_err_at_object)
        gen_flags[`CANSIL_GF_CRC] <= 1'b1; // RQ12 RQ25
      else if (cansil_git_clr(wr_ok, i_avs_address, wdat[`CANSIL_GF_CRC]))
        gen_flags[`CANSIL_GF_CRC] <= 1'b0; // RQ7
      if (i_err_form && !i_err_at_object)
        gen_flags[`CANSIL_GF_FORM] <= 1'b1; // RQ13 RQ25
      else if (cansil_git_clr(wr_ok, i_avs_address, wdat[`CANSIL_GF_FORM]))
        gen_flags[`CANSIL_GF_FORM] <= 1'b0; // RQ7
      if (i_err_ack && !i_err_at_object)
        gen_flags[`CANSIL_GF_ACK] <= 1'b1; // RQ14 RQ25
      else if (cansil_git_clr(wr_ok, i_avs_address, wdat[`CANSIL_GF_ACK]))
        gen_flags[`CANSIL_GF_ACK] <= 1'b0; // RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      gen_enables <= `CANSIL_RST_BYTE;
      obj_ie <= 6'h00;
      bt1 <= `CANSIL_RST_BYTE;
      ctrl <= `CANSIL_RST_BYTE;
    end
    else if (wr_ok)
    begin
      if (i_avs_address == `CANSIL_IDX_GIE)
        gen_enables <= wdat; // RQ15 RQ16 RQ17
      else if (i_avs_address == `CANSIL_IDX_OIE_LO)
        obj_ie <= wdat[5:0]; // RQ20
      else if (i_avs_address == `CANSIL_IDX_BT1)
        bt1 <= cansil_wr_byte(bt1, wdat, `CANSIL_BT1_MASK); // RQ22
      else if (i_avs_address == `CANSIL_IDX_CTRL)
        ctrl <= wdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Object in-use and pending bits
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      in_use <= 6'h00;
      obj_pend <= 6'h00;
    end
    else if (i_ce)
    begin
      if (abort || state == ST_STANDBY)
        in_use <= 6'h00; // RQ19
      else
        in_use <= (in_use | i_obj_config_enable) // RQ18
          & ~(i_obj_tx_ok | i_obj_rx_ok) & ~i_obj_config_disable; // RQ18 RQ19
      // Pending follows object flags gated by global enables
      obj_pend <= (i_obj_rx_ok & {6{gen_enables[`CANSIL_GE_RX]}})
        | (i_obj_tx_ok & {6{gen_enables[`CANSIL_GE_TX]}})
        | (i_obj_error & {6{gen_enables[`CANSIL_GE_OERR]}}); // RQ24 RQ21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, registered with the acknowledge
  always @(posedge i_clk)
  begin
    if (i_rst)
      o_avs_readdata <= 32'h00000000;
    else if (i_ce && i_avs_read && !ack_done)
    begin
      if (i_avs_address == `CANSIL_IDX_GSTA)
        o_avs_readdata <= cansil_byte_word(next_stat);
      else if (i_avs_address == `CANSIL_IDX_GIT)
        o_avs_readdata <= cansil_byte_word(next_flags);
      else if (i_avs_address == `CANSIL_IDX_GIE)
        o_avs_readdata <= cansil_byte_word(gen_enables);
      else if (i_avs_address == `CANSIL_IDX_INUSE_LO)
        o_avs_readdata <= cansil_byte_word({2'b00, in_use});
      else if (i_avs_address == `CANSIL_IDX_OIE_LO)
        o_avs_readdata <= cansil_byte_word({2'b00, obj_ie});
      else if (i_avs_address == `CANSIL_IDX_PEND_LO)
        o_avs_readdata <= cansil_byte_word({2'b00, obj_pend}); // RQ21
      // High halves of the object registers hold no bits
      else if (i_avs_address == `CANSIL_IDX_INUSE_HI)
        o_avs_readdata <= cansil_byte_word(8'h00);
      else if (i_avs_address == `CANSIL_IDX_OIE_HI)
        o_avs_readdata <= cansil_byte_word(8'h00); // RQ20
      else if (i_avs_address == `CANSIL_IDX_PEND_HI)
        o_avs_readdata <= cansil_byte_word(8'h00); // RQ21
      else if (i_avs_address == `CANSIL_IDX_BT1)
        o_avs_readdata <= cansil_byte_word(bt1 & `CANSIL_BT1_MASK);
      else if (i_avs_address == `CANSIL_IDX_CTRL)
        o_avs_readdata <= cansil_byte_word(ctrl);
      else
        o_avs_readdata <= 32'h00000000;
    end
  end

endmodule // cansil_top

/* File: tb/cansil_bus_model.sv */
// Behavioural CAN bus as seen by the controller
`timescale 1ns/1ps
module cansil_bus_model
(
  input wire i_clk,
  input wire i_tq_tick,
  input wire i_traffic,
  output logic o_bus_level
);
  logic [1:0] phase = 2'h0;
  // Traffic: a dominant bit every third quantum
  always @(posedge i_clk)
  begin
    if (i_tq_tick)
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
  end
  // Idle bus is pulled to the recessive level
  assign o_bus_level = i_traffic ? (phase != 2'h0) : 1'h1;
endmodule // cansil_bus_model

/* File: tb/cansil_top_chk.sv */
// Port-level assertions of the CAN status and interrupt block
`timescale 1ns/1ps
module cansil_top_chk
(
  input wire i_clk,
  input wire i_rst,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_bus_recessive_bit,
  input wire i_timer_wrap,
  input wire i_overrun_handler_entry,
  input wire o_tq_tick,
  input wire o_controller_enabled_state,
  input wire o_controller_irq,
  input wire o_timer_overrun_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire req = i_avs_read | i_avs_write;
  logic [3:0] rec_cnt;
  // Run of recessive samples on quantum ticks
  always @(posedge i_clk)
  begin
    if (i_rst || (o_tq_tick && !i_bus_recessive_bit))
      rec_cnt <= 4'h0;
    else if (o_tq_tick && rec_cnt != 4'hF)
      rec_cnt <= rec_cnt + 4'h1;
  end
  // Bus handshake
  a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("new request not held off");
  a_wait_once: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait cycle");
  a_idle_free: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest while idle");
  a_rdata_hold: assert property (!i_avs_read && !$past(i_avs_read) |=> $stable(o_avs_readdata))
    else $error("read data moved without a read");
  // Interrupt requests
  a_timer_cause: assert property ($rose(o_timer_overrun_irq) |-> $past(i_timer_wrap) || $past(i_avs_write))
    else $error("timer request without wrap or write");
  a_handler_clear: assert property (i_overrun_handler_entry && !i_timer_wrap |=> !o_timer_overrun_irq)
    else $error("handler entry left timer request");
  a_ctrl_no_wrap: assert property ($rose(o_controller_irq) |-> !$past(i_timer_wrap))
    else $error("timer wrap raised controller request");
  a_enable_lag: assert property ($rose(o_controller_enabled_state) |-> rec_cnt >= 4'hB)
    else $error("enabled before recessive run");
endmodule // cansil_top_chk

bind cansil_top cansil_top_chk cansil_top_chk_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_bus_recessive_bit(i_bus_recessive_bit),
  .i_timer_wrap(i_timer_wrap), .i_overrun_handler_entry(i_overrun_handler_entry),
  .o_tq_tick(o_tq_tick), .o_controller_enabled_state(o_controller_enabled_state),
  .o_controller_irq(o_controller_irq), .o_timer_overrun_irq(o_timer_overrun_irq));

/* File: tb/cansil_top_bench.sv */
// Self-checking bench of the CAN status and interrupt block
`timescale 1ns/1ps
module cansil_top_bench;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [3:0] adr = 4'h0;
  logic avs_rd = 1'h0;
  logic avs_wr = 1'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic wait_rq, tick_q, en_q, irq_c, irq_t, bus_lvl;
  logic [3:0] lv = 4'h0;
  logic [6:0] pul = 7'h00;
  logic [29:0] ov = 30'h0;
  logic eobj = 1'h0;
  logic fbrw = 1'h1;
  logic traffic = 1'h0;
  logic ce = 1'h1;
  logic [3:0] be = 4'h1;
  logic [7:0] tbl [4] = '{8'h7E, 8'h80, 8'h82, 8'h01};
  int fails = 0;
  int n_checks = 0;
  // Clock
  always #5 i_clk = !i_clk;
  cansil_top cansil_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_avs_address(adr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq), .i_transmitter_active(lv[3]),
    .i_receiver_active(lv[2]), .i_bus_recessive_bit(bus_lvl), .i_bus_off_state(lv[1]),
    .i_error_passive_state(lv[0]), .i_timer_wrap(pul[5]), .i_overrun_handler_entry(pul[6]),
    .i_frame_buffer_done(pul[4]), .i_fbuf_config_rewritten(fbrw), .i_err_stuff(pul[3]),
    .i_err_crc(pul[2]), .i_err_form(pul[1]), .i_err_ack(pul[0]), .i_err_at_object(eobj),
    .i_obj_config_enable(ov[5:0]), .i_obj_config_disable(ov[11:6]), .i_obj_rx_ok(ov[17:12]),
    .i_obj_tx_ok(ov[23:18]), .i_obj_error(ov[29:24]), .o_controller_enabled_state(en_q),
    .o_tq_tick(tick_q), .o_controller_irq(irq_c), .o_timer_overrun_irq(irq_t));
  cansil_bus_model cansil_bus_model_i (.i_clk(i_clk), .i_tq_tick(tick_q), .i_traffic(traffic),
    .o_bus_level(bus_lvl));
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and expectation helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] gflags(input logic [6:0] f);
    return {f[6] | (|f[4:0]), f};
  endfunction
  function automatic logic [1:0] irqs(input logic [7:0] ge, input logic [6:0] f);
    return {ge[7] & ((ge[6] & f[6]) | (ge[2] & f[4]) | (ge[1] & (|f[3:0]))), ge[0] & f[5]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus transfer held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wdat <= {24'h000000, d};
    avs_rd <= !w;
    avs_wr <= w;
    @(posedge i_clk);
    while (wait_rq !== 1'h0 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20)
      fails++;
    q = rdat;
    avs_rd <= 1'h0;
    avs_wr <= 1'h0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
    bus(1'h0, a, 8'h00);
    chk(nm, q, {24'h000000, e});
  endtask
  task automatic drive(input logic [6:0] p, input logic [29:0] v);
    @(posedge i_clk);
    pul <= p;
    ov <= v;
    @(posedge i_clk);
    pul <= 7'h00;
    ov <= 30'h0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic setlv(input logic [3:0] v);
    @(posedge i_clk);
    lv <= v;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic tick(output int c);
    c = 0;
    do
    begin
      @(posedge i_clk);
      c++;
    end
    while (tick_q !== 1'h1 && c < 300);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fails++;
    finish_test;
  end
  // Main sequence
  initial
  begin
    logic [7:0] r, s, ge, ie, e;
    logic [6:0] f;
    int n, c;
    r = 8'h3A;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'h0;
    for (int a = 0; a < 16; a++)
      rchk(4'(a), 8'h00, "reset value");
    $display("test reset done");
    repeat (6)
    begin
      r = lfsr(r);
      setlv(r[3:0]);
      rchk(4'h0, {3'h0, r[3:2], 1'h0, r[1:0]}, "status");
    end
    setlv(4'h2);
    bus(1'h1, 4'h1, 8'hFF);
    rchk(4'h1, 8'h00, "bus off held");
    setlv(4'h1);
    setlv(4'h2);
    setlv(4'h0);
    rchk(4'h1, 8'hC0, "bus off entry");
    bus(1'h1, 4'h1, 8'h40);
    eobj <= 1'h1;
    drive(7'h0F, 30'h0);
    eobj <= 1'h0;
    rchk(4'h1, 8'h00, "object level error");
    ce <= 1'h0;
    drive(7'h0F, 30'h0);
    ce <= 1'h1;
    rchk(4'h1, 8'h00, "frozen by clock enable");
    $display("test status done");
    f = 7'h00;
    for (int i = 0; i < 10; i++)
    begin
      r = lfsr(r);
      s = lfsr(r);
      ge = (i < 4) ? tbl[i] : lfsr(s);
      drive({2'h0, r[4:0]}, 30'h0);
      drive({1'h0, r[5], 5'h00}, 30'h0); // Wrap apart from controller sources
      f = f | {1'h0, r[5:0]};
      if (r[6])
      begin
        drive(7'h40, 30'h0);
        f[5] = 1'h0;
      end
      bus(1'h1, 4'h1, s & 8'h55);
      f = f & ~s[6:0] | f & ~7'h55;
      rchk(4'h1, gflags(f), "flags");
      bus(1'h1, 4'h2, ge);
      rchk(4'h2, ge, "enables");
      chk("requests", {irq_c, irq_t}, irqs(ge, f));
    end
    drive(7'h10, 30'h0);
    fbrw <= 1'h0;
    bus(1'h1, 4'h1, 8'h10);
    rchk(4'h1, gflags(f | 7'h10), "buffer flag held");
    fbrw <= 1'h1;
    bus(1'h1, 4'h1, 8'h7F);
    rchk(4'h1, 8'h00, "flags cleared");
    $display("test flags done");
    bus(1'h1, 4'h9, 8'h06);
    rchk(4'h9, 8'h06, "prescaler");
    be <= 4'h0;
    bus(1'h1, 4'h9, 8'h7E);
    be <= 4'h1;
    rchk(4'h9, 8'h06, "lane off write");
    tick(c);
    tick(c);
    chk("quantum", c, 4);
    traffic <= 1'h1;
    bus(1'h1, 4'hA, 8'h02);
    repeat (60) @(posedge i_clk);
    chk("enabled on busy bus", en_q, 1'h0);
    traffic <= 1'h0;
    n = 0;
    while (en_q !== 1'h1 && n < 40)
    begin
      tick(c);
      n++;
    end
    chk("enable lag", n > 8 && n < 14, 1'h1);
    rchk(4'h0, 8'h04, "enabled status");
    ie = lfsr(r) & 8'h3F;
    bus(1'h1, 4'h5, ie);
    rchk(4'h5, ie, "object enables");
    drive(7'h00, 30'h3F);
    rchk(4'h3, 8'h3F, "in use");
    drive(7'h00, {6'h00, 6'h04, 6'h02, 6'h08, 6'h00});
    rchk(4'h3, 8'h31, "in use cleared");
    bus(1'h1, 4'hA, 8'h82);
    rchk(4'h3, 8'h00, "abort");
    bus(1'h1, 4'hA, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      r = lfsr(r);
      s = lfsr(r);
      ge = {r[7], 1'h0, r[5:3], 3'h0};
      bus(1'h1, 4'h2, ge);
      ov <= {s[5:0], r[5:0] ^ s[5:0], s[7:2], 12'h000};
      e = {2'h0, (s[7:2] & {6{ge[5]}}) | ((r[5:0] ^ s[5:0]) & {6{ge[4]}})
        | (s[5:0] & {6{ge[3]}})};
      rchk(4'h7, e, "pending");
      chk("pending request", irq_c, ge[7] & (|(e & ie)));
      ov <= 30'h0;
    end
    $display("test objects done");
    drive(7'h00, 30'h01);
    rchk(4'h3, 8'h01, "in use before standby");
    bus(1'h1, 4'hA, 8'h00);
    repeat (20) @(posedge i_clk);
    rchk(4'h3, 8'h00, "standby");
    rchk(4'h0, 8'h00, "standby status");
    $display("test enable done");
    finish_test;
  end
endmodule // cansil_top_bench
